// [shared/mcr_pkg.sv]
// Package: register map, field positions and constants of the control bank
package mcr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] OFS_DOUBLER_START = 16'hf091;
	localparam logic [15:0] OFS_CLK_DIV_CTRL  = 16'hf09e;
	localparam logic [15:0] OFS_LINK_XFER     = 16'hf0a1;
	localparam logic [15:0] OFS_LINK_STATUS   = 16'hf0a2;
	localparam logic [15:0] OFS_MODULATOR     = 16'hf0b3;
	localparam logic [15:0] OFS_ROUTE_LED     = 16'hf0b9;
	localparam logic [15:0] OFS_SWITCH        = 16'hf0ba;
	localparam logic [15:0] OFS_BAUD_PARITY   = 16'hf0c0;
	localparam logic [15:0] OFS_AUDIO_SWAP    = 16'hf0c1;
	localparam logic [15:0] OFS_PIN_CTRL      = 16'hf0c2;
	localparam logic [15:0] OFS_JUMPER        = 16'hf0c9;
	localparam logic [15:0] OFS_SYNTH_TEST    = 16'hf0d8;
	localparam logic [15:0] OFS_FRAME_LO      = 16'hf0f6;
	localparam logic [15:0] OFS_FRAME_HI      = 16'hf0f7;
	localparam logic [15:0] OFS_PAGE          = 16'hf0ff;

	// ----------------------------------------------------------------
	// Address windows
	// ----------------------------------------------------------------
	localparam logic [15:0] WIN_FRAME0  = 16'h8000;
	localparam logic [15:0] WIN_UNUSED  = 16'hb000;
	localparam logic [15:0] WIN_REGS    = 16'hf000;
	localparam logic [20:0] FRAME_BYTES = 21'h000c00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_STABLE     = 6;
	localparam int BIT_DOUBLER    = 7;
	localparam int BIT_QINV       = 3;
	localparam int BIT_SUBINV     = 4;
	localparam int BIT_EVEN_PAR   = 5;
	localparam int BIT_USE_INPUT  = 5;
	localparam int BIT_STABLE_OUT = 2;
	localparam int BIT_BYTE_SWAP  = 2;
	localparam int BIT_QUARTER    = 3;
	localparam int BIT_SAMPLE_CNT = 6;
	localparam int BIT_CLK_SRC    = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [8:0] RST_FRAME = 9'h000;
	localparam logic [4:0] RST_PAGE  = 5'h00;

	// Audio routing
	typedef enum logic [1:0] {
		MCR_ROUTE_MUTE, MCR_ROUTE_RIGHT, MCR_ROUTE_LEFT, MCR_ROUTE_STEREO
	} mcr_route_t;

	// Microcontroller access
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mcr_cpu_req_t;

	// Serial link status
	typedef struct packed {
		logic rx_valid;
		logic rx_overwrite;
		logic parity_fault;
		logic tx_empty;
		logic request_to_send_flag;
	} mcr_link_stat_t;

	// Buffer request
	typedef struct packed {
		logic        lin;
		logic [19:0] addr;
	} mcr_buf_req_t;

endpackage

// [rtl/mcr_bank.sv]
// Miscellaneous control and status register bank
// What this block does
// R1: Low 32 kbyte CPU window addresses buffer linearly using the page register.
// R2: Frame window 0 address is frame number times 3k plus 12 LSBs.
// R3: Frame windows 1 and 2 use frame number plus one and plus two.
// R4: Reads from the unused range return zero.
// R5: Any write to doubler start engages the clock doubler.
// R6: Doubler off after reset, stays on until a reset source.
// R7: Baud bit 6 shows synth stable; bit 7 reads doubler engaged.
// R8: Bypass bit powers down synthesizer and selects input clock.
// R9: Channel field routes audio, bits 2-3 mute, bit 4 LED low.
// R10: Switch register reports tray and active-low front panel requests.
// R11: Jumper register returns the byte caught from buffer bus on the first cycle after each reset release.
// R12: Pin direction bits reset low as inputs; high makes outputs.
// R13: Direction reads back; data reads pin in input, latch in output.
// R14: Link status flags rx valid, overwrite, parity error, tx empty.
// R15: Clear-to-send drops on stop bit, rises when byte is read.
// R16: Request-to-send interrupt raised when tx ready and unmasked.
// R17: Baud select chooses 31.25, 62.5 or 187.5 kbaud.
// R18: Bits 3,4,5 invert Q-channel, invert sub-code, select even parity.
// R19: Six-bit divisor sets CPU serial clock from 16.945 MHz source.
// R20: Bit 7 routes counter clock to CPU; bit 6 samples by counter.
// R21: Byte swap bit low swaps audio bytes; high keeps data order.
// R22: Quarter rate bit samples sub-code and C-flag at quarter rate.
// R23: Linear address is 15 CPU bits plus 32768 times page.
// R24: Frame counter loads on high byte write, held while access busy.
// R25: Writes act on next edge; unimplemented bits read zero.
`timescale 1ns/100ps
module mcr_bank
	import mcr_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_sys_i,
	input  wire logic          rst_n_i,
	// Microcontroller bus
	input  wire mcr_cpu_req_t  cpu_req_i,
	output logic [7:0]         cpu_rdata_o,
	// Buffer memory port
	output mcr_buf_req_t       buf_req_o,
	output logic               buf_valid_o,
	input  wire logic          buf_ready_i,
	input  wire logic          buf_busy_i,
	input  wire logic [7:0]    buf_rdata_i,
	input  wire logic [7:0]    buf_bus_i,
	// Clock control
	input  wire logic          synth_stable_i,
	output logic               doubler_on_o,
	output logic               synth_bypass_o,
	output logic               stable_test_out_o,
	output logic [1:0]         synth_test_o,
	// Audio and LED
	output mcr_route_t         route_o,
	output logic               right_silence_o,
	output logic               left_silence_o,
	output logic               led_n_o,
	output logic               led_oe_o,
	output logic               byte_swap_sel_o,
	output logic               quarter_rate_sample_o,
	output logic               test_mux_o,
	// Front panel
	input  wire logic [4:0]    switch_i,
	// General pins
	input  wire logic [3:0]    pin_i,
	output logic [3:0]         pin_o,
	output logic [3:0]         pin_oe_o,
	// Engine serial link
	input  wire mcr_link_stat_t link_stat_i,
	input  wire logic [7:0]    link_rx_byte_i,
	input  wire logic          link_stop_bit_i,
	output logic               clear_to_send_flag_o,
	output logic               link_rx_read_o,
	output logic               link_tx_wr_o,
	output logic [7:0]         link_tx_byte_o,
	output logic [1:0]         baud_rate_sel_o,
	output logic               qchannel_invert_o,
	output logic               subcode_invert_o,
	output logic               even_parity_sel_o,
	input  wire logic          tx_ready_flag_i,
	input  wire logic          rts_irq_mask_i,
	output logic               rts_irq_o,
	// CPU serial clock
	output logic [5:0]         clock_divisor_o,
	output logic               serial_clock_source_o,
	output logic               sample_from_counter_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [9:0] s1, s2, s3, pins_q;
	always_ff @(posedge clk_sys_i) begin
		s1 <= {pin_i, switch_i, synth_stable_i};
		s2 <= s1;
		s3 <= s2;
		if (!rst_n_i)
			pins_q <= 10'h000;
		else if (s2 == s3)
			pins_q <= s3;
	end
	wire logic [3:0] pin_live   = pins_q[9:6];
	wire logic [4:0] switch_q   = pins_q[5:1];
	wire logic       stable_q   = pins_q[0];

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire logic [15:0] a      = cpu_req_i.addr;
	wire logic        in_lin = a < WIN_FRAME0;
	wire logic        in_frm = (a >= WIN_FRAME0) && (a < WIN_UNUSED);
	wire logic        in_reg = a >= WIN_REGS;
	wire logic        wr     = cpu_req_i.wr;
	wire logic [7:0]  wd     = cpu_req_i.wdata;
	wire logic [1:0]  frm_sel = 2'(a[13:12] - 2'h0);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic       doubler;
	logic [7:0] baud, swap, pins, synth, divc, route;
	logic [8:0] frame, frame_stage;
	logic [7:0] frame_lo;
	logic       frame_pend;
	logic [4:0] page;
	logic [7:0] jumper;
	logic       jumper_done;
	logic       cts;

	// R25: write strobes
	wire logic w_dbl   = wr && in_reg && a == OFS_DOUBLER_START;
	wire logic w_baud  = wr && in_reg && a == OFS_BAUD_PARITY;
	wire logic w_swap  = wr && in_reg && a == OFS_AUDIO_SWAP;
	wire logic w_pins  = wr && in_reg && a == OFS_PIN_CTRL;
	wire logic w_synth = wr && in_reg && a == OFS_SYNTH_TEST;
	wire logic w_div   = wr && in_reg && a == OFS_CLK_DIV_CTRL;
	wire logic w_route = wr && in_reg && a == OFS_ROUTE_LED;
	wire logic w_flo   = wr && in_reg && a == OFS_FRAME_LO;
	wire logic w_fhi   = wr && in_reg && a == OFS_FRAME_HI;
	wire logic w_page  = wr && in_reg && a == OFS_PAGE;
	wire logic w_tx    = wr && in_reg && a == OFS_LINK_XFER;
	wire logic r_rx    = cpu_req_i.rd && in_reg && a == OFS_LINK_XFER;

	// R5: doubler start
	// R6: held until reset
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			doubler <= 1'b0;
		else if (w_dbl || (w_baud && wd[BIT_DOUBLER] && stable_q))
			doubler <= 1'b1;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			baud  <= RST_BYTE;
			swap  <= RST_BYTE;
			pins  <= RST_BYTE;
			synth <= RST_BYTE;
			divc  <= RST_BYTE;
			route <= RST_BYTE;
			page  <= RST_PAGE;
		end else begin
			if (w_baud)
				baud <= wd & 8'h3b;
			if (w_swap)
				swap <= wd & 8'h8c;
			if (w_pins)
				pins <= wd;
			if (w_synth)
				synth <= wd & 8'h3c;
			if (w_div)
				divc <= wd;
			if (w_route)
				route <= wd & 8'h1f;
			if (w_page)
				page <= wd[4:0];
		end
	end

	// R24: frame counter load
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			frame       <= RST_FRAME;
			frame_lo    <= RST_BYTE;
			frame_stage <= RST_FRAME;
			frame_pend  <= 1'b0;
		end else begin
			if (w_flo)
				frame_lo <= wd;
			if (w_fhi) begin
				frame_stage <= {wd[0], frame_lo};
				frame_pend  <= 1'b1;
			end else if (frame_pend && !buf_busy_i) begin
				frame      <= frame_stage;
				frame_pend <= 1'b0;
			end
		end
	end

	// R11: jumper capture after reset release
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			jumper      <= RST_BYTE;
			jumper_done <= 1'b0;
		end else if (!jumper_done) begin
			jumper      <= buf_bus_i;
			jumper_done <= 1'b1;
		end
	end

	// R15: clear-to-send
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			cts <= 1'b1;
		else if (link_stop_bit_i)
			cts <= 1'b0;
		else if (r_rx)
			cts <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Buffer address generation
	// ----------------------------------------------------------------
	// R3: frame offset per window
	wire logic [8:0]  frm_num  = 9'(frame + {7'h00, frm_sel});
	// R2: frame times 3k plus 12 LSBs
	wire logic [19:0] frm_addr =
		20'(21'(frm_num) * FRAME_BYTES + {9'h000, a[11:0]});
	// R1: linear window
	// R23: page times 32768
	wire logic [19:0] lin_addr = {page, a[14:0]};
	wire logic        buf_acc  = (cpu_req_i.rd || wr) && (in_lin || in_frm);

	// ----------------------------------------------------------------
	// Two-entry buffer on the buffer-memory request path
	// ----------------------------------------------------------------
	mcr_buf_req_t q [2];
	logic [1:0]   cnt;
	logic         rp, wp;
	wire logic    push = buf_acc && cnt != 2'h2;
	wire logic    pop  = buf_valid_o && buf_ready_i;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cnt <= 2'h0;
			rp  <= 1'b0;
			wp  <= 1'b0;
		end else begin
			if (push) begin
				q[wp] <= '{lin: in_lin, addr: in_lin ? lin_addr : frm_addr};
				wp    <= ~wp;
			end
			if (pop)
				rp <= ~rp;
			cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
		end
	end
	assign buf_valid_o = cnt != 2'h0;
	assign buf_req_o   = buf_valid_o ? q[rp] : '0;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// R13: pin data read
	wire logic [3:0] pin_dir = {pins[6], pins[4], pins[2], pins[0]};
	wire logic [3:0] pin_lat = {pins[7], pins[5], pins[3], pins[1]};
	wire logic [3:0] pin_rd  = (pin_dir & pin_lat) | (~pin_dir & pin_live);
	wire logic [7:0] pin_byte = {pin_rd[3], pin_dir[3], pin_rd[2],
		pin_dir[2], pin_rd[1], pin_dir[1], pin_rd[0], pin_dir[0]};
	// R14: status byte
	wire logic [7:0] stat_byte = {2'h0,
		link_stat_i.request_to_send_flag, cts, link_stat_i.tx_empty,
		link_stat_i.parity_fault, link_stat_i.rx_overwrite,
		link_stat_i.rx_valid};
	// R7: stable and doubler read
	wire logic [7:0] baud_byte = {doubler, stable_q, baud[5:0]};

	logic [7:0] reg_rd;
	always_comb begin
		case (a)
		OFS_CLK_DIV_CTRL: reg_rd = divc;
		OFS_LINK_XFER:    reg_rd = link_rx_byte_i;
		OFS_LINK_STATUS:  reg_rd = stat_byte;
		// R10: switches
		OFS_SWITCH:       reg_rd = {3'h0, switch_q};
		OFS_BAUD_PARITY:  reg_rd = baud_byte;
		OFS_AUDIO_SWAP:   reg_rd = swap;
		OFS_PIN_CTRL:     reg_rd = pin_byte;
		OFS_JUMPER:       reg_rd = jumper;
		OFS_SYNTH_TEST:   reg_rd = synth;
		OFS_FRAME_LO:     reg_rd = frame[7:0];
		OFS_FRAME_HI:     reg_rd = {7'h00, frame[8]};
		OFS_PAGE:         reg_rd = {3'h0, page};
		// R25: unmapped reads zero
		default:          reg_rd = 8'h00;
		endcase
	end

	// R4: unused range drives zero
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			cpu_rdata_o <= 8'h00;
		else if (in_reg)
			cpu_rdata_o <= reg_rd;
		else if (in_lin || in_frm)
			cpu_rdata_o <= buf_rdata_i;
		else
			cpu_rdata_o <= 8'h00;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign doubler_on_o          = doubler;
	// R8: synth bypass
	assign synth_bypass_o        = synth[BIT_USE_INPUT];
	assign stable_test_out_o     = synth[BIT_STABLE_OUT];
	assign synth_test_o          = synth[4:3];
	// R9: audio route
	assign route_o               = mcr_route_t'(route[1:0]);
	assign right_silence_o       = route[2];
	assign left_silence_o        = route[3];
	assign led_n_o               = route[4];
	assign led_oe_o              = ~synth[BIT_STABLE_OUT];
	// R21: byte swap
	assign byte_swap_sel_o       = swap[BIT_BYTE_SWAP];
	// R22: quarter rate
	assign quarter_rate_sample_o = swap[BIT_QUARTER];
	assign test_mux_o            = swap[7];
	// R12: pin direction
	assign pin_o                 = pin_lat;
	assign pin_oe_o              = pin_dir;
	assign clear_to_send_flag_o  = cts;
	assign link_rx_read_o        = r_rx;
	assign link_tx_wr_o          = w_tx;
	assign link_tx_byte_o        = wd;
	// R17: baud select
	assign baud_rate_sel_o       = baud[1:0];
	// R18: inversions and parity
	assign qchannel_invert_o     = baud[BIT_QINV];
	assign subcode_invert_o      = baud[BIT_SUBINV];
	assign even_parity_sel_o     = baud[BIT_EVEN_PAR];
	// R16: request-to-send interrupt
	assign rts_irq_o = link_stat_i.request_to_send_flag && tx_ready_flag_i
		&& rts_irq_mask_i;
	// R19: divisor
	assign clock_divisor_o       = divc[5:0];
	// R20: clock source and sampling
	assign serial_clock_source_o = divc[BIT_CLK_SRC];
	assign sample_from_counter_o = divc[BIT_SAMPLE_CNT];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	doubler_hold_a: assert property (doubler |=> doubler) // R6
		else $error("doubler dropped");
	doubler_start_a: assert property (w_dbl |=> doubler_on_o) // R5
		else $error("doubler not engaged");
	unused_zero_a: assert property (!in_lin && !in_frm && !in_reg
		|=> cpu_rdata_o == 8'h00) // R4
		else $error("unused range not zero");
	cts_drop_a: assert property (link_stop_bit_i |=> !cts) // R15
		else $error("cts not dropped");
	pin_dir_a: assert property (w_pins |=> pin_oe_o[0] == $past(wd[0])) // R12
		else $error("direction not written");
	lin_addr_a: assert property (in_lin && push && cnt == 2'h0
		|=> buf_req_o.addr[14:0] == $past(a[14:0])) // R1
		else $error("linear address wrong");
	frame_load_a: assert property (w_flo ##1 !buf_busy_i && !w_fhi
		|=> frame == $past(frame)) // R24
		else $error("frame loaded on low byte");
	rts_irq_a: assert property (rts_irq_o |-> tx_ready_flag_i) // R16
		else $error("irq without tx ready");
endmodule

// [tb/mcr_buf_model.sv]
// Buffer memory model at the far side of the request queue
`timescale 1ns/100ps
module mcr_buf_model
	import mcr_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	// Stall control from the bench
	input  wire logic         stall_i,
	// Request side
	input  wire mcr_buf_req_t buf_req_i,
	input  wire logic         buf_valid_i,
	output logic              buf_ready_o,
	output logic [7:0]        buf_rdata_o
);
	mcr_buf_req_t got[$];
	logic [7:0]   pat = 8'h5a;

	// Ready drops while the bench stalls; data changes every cycle
	assign buf_ready_o = !stall_i;
	assign buf_rdata_o = pat;

	always @(posedge clk_sys_i) begin
		pat <= pat + 8'h3b;
		if (rst_n_i && buf_valid_i && buf_ready_o) begin
			got.push_back(buf_req_i);
		end
	end
endmodule

// [tb/mcr_bank_tb_top.sv]
// Self-checking testbench of the control register bank
`timescale 1ns/100ps
module mcr_bank_tb_top
	import mcr_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic           clk_sys_i = 1'b0, rst_n_i = 1'b0;
	mcr_cpu_req_t   cpu_req_i = '0;
	logic           buf_busy_i = 1'b0, synth_stable_i = 1'b1;
	logic           link_stop_bit_i = 1'b0, tx_ready_flag_i = 1'b0;
	logic           rts_irq_mask_i = 1'b0, stall = 1'b1;
	logic [7:0]     buf_bus_i = 8'ha5, link_rx_byte_i = 8'h5a;
	logic [4:0]     switch_i = 5'h15;
	logic [3:0]     pin_i = 4'h4;
	mcr_link_stat_t link_stat_i = '0;
	logic           buf_ready_i, buf_valid_o, doubler_on_o, synth_bypass_o;
	logic [7:0]     buf_rdata_i, cpu_rdata_o, link_tx_byte_o;
	mcr_buf_req_t   buf_req_o;
	mcr_route_t     route_o;
	logic           stable_test_out_o, right_silence_o, left_silence_o;
	logic           led_n_o, led_oe_o, byte_swap_sel_o, test_mux_o;
	logic           quarter_rate_sample_o, clear_to_send_flag_o;
	logic           link_rx_read_o, link_tx_wr_o, qchannel_invert_o;
	logic           subcode_invert_o, even_parity_sel_o, rts_irq_o;
	logic           serial_clock_source_o, sample_from_counter_o;
	logic [1:0]     synth_test_o, baud_rate_sel_o;
	logic [3:0]     pin_o, pin_oe_o;
	logic [5:0]     clock_divisor_o;
	int             num_errors = 0, n_compared = 0;

	always #2 clk_sys_i = ~clk_sys_i;

	mcr_buf_model u_mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.stall_i(stall), .buf_req_i(buf_req_o), .buf_valid_i(buf_valid_o),
		.buf_ready_o(buf_ready_i), .buf_rdata_o(buf_rdata_i));
	mcr_bank dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_req_i(cpu_req_i),
		.cpu_rdata_o(cpu_rdata_o), .buf_req_o(buf_req_o),
		.buf_valid_o(buf_valid_o), .buf_ready_i(buf_ready_i),
		.buf_busy_i(buf_busy_i), .buf_rdata_i(buf_rdata_i),
		.buf_bus_i(buf_bus_i), .synth_stable_i(synth_stable_i),
		.doubler_on_o(doubler_on_o), .synth_bypass_o(synth_bypass_o),
		.stable_test_out_o(stable_test_out_o),
		.synth_test_o(synth_test_o),
		.route_o(route_o), .right_silence_o(right_silence_o),
		.left_silence_o(left_silence_o), .led_n_o(led_n_o),
		.led_oe_o(led_oe_o), .byte_swap_sel_o(byte_swap_sel_o),
		.quarter_rate_sample_o(quarter_rate_sample_o),
		.test_mux_o(test_mux_o), .switch_i(switch_i), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_o(pin_oe_o), .link_stat_i(link_stat_i),
		.link_rx_byte_i(link_rx_byte_i),
		.link_stop_bit_i(link_stop_bit_i),
		.clear_to_send_flag_o(clear_to_send_flag_o),
		.link_rx_read_o(link_rx_read_o), .link_tx_wr_o(link_tx_wr_o),
		.link_tx_byte_o(link_tx_byte_o),
		.baud_rate_sel_o(baud_rate_sel_o),
		.qchannel_invert_o(qchannel_invert_o),
		.subcode_invert_o(subcode_invert_o),
		.even_parity_sel_o(even_parity_sel_o),
		.tx_ready_flag_i(tx_ready_flag_i),
		.rts_irq_mask_i(rts_irq_mask_i),
		.rts_irq_o(rts_irq_o), .clock_divisor_o(clock_divisor_o),
		.serial_clock_source_o(serial_clock_source_o),
		.sample_from_counter_o(sample_from_counter_o));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		cpu_req_i = '{1'b0, 1'b1, a, d};
		@(negedge clk_sys_i);
		cpu_req_i.wr = 1'b0;
	endtask

	task automatic bacc(input logic [15:0] a);
		@(negedge clk_sys_i);
		cpu_req_i = '{1'b1, 1'b0, a, 8'h00};
		@(negedge clk_sys_i);
		cpu_req_i.rd = 1'b0;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] e, string nm);
		bacc(a);
		chk(nm, cpu_rdata_o, e);
	endtask

	function automatic logic [20:0] fa(int f, logic [11:0] o);
		return {1'b0, 20'(f * FRAME_BYTES + o)};
	endfunction

	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rchk(OFS_BAUD_PARITY, 8'h40, "baud");
		chk("doubler", doubler_on_o, 0);
		chk("pin_oe", pin_oe_o, 0);
		chk("cts", clear_to_send_flag_o, 1);
		synth_stable_i = 1'b0;
		repeat (5) @(negedge clk_sys_i);
		rchk(OFS_BAUD_PARITY, 8'h00, "baud");
		wr(OFS_BAUD_PARITY, 8'h80);
		chk("doubler", doubler_on_o, 0);
		synth_stable_i = 1'b1;
		repeat (5) @(negedge clk_sys_i);
		$display("done reset");
	endtask

	task automatic t_doubler;
		wr(OFS_DOUBLER_START, 8'h00);
		chk("doubler", doubler_on_o, 1);
		rchk(OFS_DOUBLER_START, 8'h00, "start_rd");
		rchk(OFS_BAUD_PARITY, 8'hc0, "baud");
		$display("done doubler");
	endtask

	task automatic t_baud;
		logic [7:0] tv[4] = '{8'h08, 8'h11, 8'h22, 8'h3b};
		foreach (tv[k]) begin
			wr(OFS_BAUD_PARITY, tv[k]);
			chk("baud_sel", baud_rate_sel_o, tv[k][1:0]);
			chk("qinv", qchannel_invert_o, tv[k][3]);
			chk("subinv", subcode_invert_o, tv[k][4]);
			chk("even", even_parity_sel_o, tv[k][5]);
			rchk(OFS_BAUD_PARITY, tv[k] | 8'hc0, "baud");
		end
		$display("done baud");
	endtask

	task automatic t_route;
		logic [7:0] tv[4] = '{8'h00, 8'h15, 8'h0a, 8'h1f};
		foreach (tv[k]) begin
			wr(OFS_ROUTE_LED, tv[k]);
			chk("route", route_o, tv[k][1:0]);
			chk("rmute", right_silence_o, tv[k][2]);
			chk("lmute", left_silence_o, tv[k][3]);
			chk("led_n", led_n_o, tv[k][4]);
			rchk(OFS_ROUTE_LED, 8'h00, "route_rd");
		end
		$display("done route");
	endtask

	task automatic t_inputs;
		rchk(OFS_SWITCH, 8'h15, "switch");
		buf_bus_i = 8'h3c;
		rchk(OFS_JUMPER, 8'ha5, "jumper");
		wr(OFS_PIN_CTRL, 8'h0f);
		chk("pin_oe", pin_oe_o, 4'h3);
		chk("pin_o", pin_o, 4'h3);
		rchk(OFS_PIN_CTRL, 8'h2f, "pins");
		pin_i = 4'h8;
		repeat (5) @(negedge clk_sys_i);
		rchk(OFS_PIN_CTRL, 8'h8f, "pins");
		$display("done inputs");
	endtask

	task automatic t_regs;
		wr(OFS_CLK_DIV_CTRL, 8'hcf);
		chk("divisor", clock_divisor_o, 6'h0f);
		chk("clk_src", serial_clock_source_o, 1);
		chk("smp_cnt", sample_from_counter_o, 1);
		rchk(OFS_CLK_DIV_CTRL, 8'hcf, "div_rd");
		wr(OFS_AUDIO_SWAP, 8'hff);
		chk("swap", byte_swap_sel_o, 1);
		chk("quarter", quarter_rate_sample_o, 1);
		chk("test_mux", test_mux_o, 1);
		rchk(OFS_AUDIO_SWAP, 8'h8c, "swap_rd");
		wr(OFS_AUDIO_SWAP, 8'h00);
		chk("swap", byte_swap_sel_o, 0);
		wr(OFS_SYNTH_TEST, 8'h3c);
		chk("bypass", synth_bypass_o, 1);
		chk("led_oe", led_oe_o, 0);
		chk("stable_out", stable_test_out_o, 1);
		chk("synth_tst", synth_test_o, 2'h3);
		rchk(OFS_SYNTH_TEST, 8'h3c, "synth_rd");
		wr(OFS_SYNTH_TEST, 8'h00);
		chk("bypass", synth_bypass_o, 0);
		wr(OFS_MODULATOR, 8'hff);
		rchk(OFS_MODULATOR, 8'h00, "rsvd_rd");
		$display("done regs");
	endtask

	task automatic t_link;
		link_stat_i = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		rchk(OFS_LINK_STATUS, 8'h1a, "link_st");
		link_stat_i = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		rchk(OFS_LINK_STATUS, 8'h35, "link_st");
		@(negedge clk_sys_i);
		link_stop_bit_i = 1'b1;
		@(negedge clk_sys_i);
		link_stop_bit_i = 1'b0;
		chk("cts", clear_to_send_flag_o, 0);
		@(negedge clk_sys_i);
		cpu_req_i = '{1'b1, 1'b0, OFS_LINK_XFER, 8'h00};
		#1 chk("rx_read", link_rx_read_o, 1);
		@(negedge clk_sys_i);
		cpu_req_i.rd = 1'b0;
		chk("rx_byte", cpu_rdata_o, 8'h5a);
		@(negedge clk_sys_i);
		chk("cts", clear_to_send_flag_o, 1);
		for (int j = 0; j < 8; j++) begin
			link_stat_i.request_to_send_flag = j[2];
			tx_ready_flag_i = j[1];
			rts_irq_mask_i = j[0];
			@(negedge clk_sys_i);
			chk("rts_irq", rts_irq_o, j == 7);
		end
		cpu_req_i = '{1'b0, 1'b1, OFS_LINK_XFER, 8'h96};
		#1 chk("tx_wr", link_tx_wr_o, 1);
		chk("tx_byte", link_tx_byte_o, 8'h96);
		@(negedge clk_sys_i);
		cpu_req_i.wr = 1'b0;
		#1 chk("tx_wr", link_tx_wr_o, 0);
		$display("done link");
	endtask

	task automatic t_buffer;
		wr(OFS_PAGE, 8'h03);
		wr(OFS_FRAME_LO, 8'h05);
		wr(OFS_FRAME_HI, 8'h00);
		bacc(16'h1234);
		chk("buf_rd", cpu_rdata_o, 8'(u_mem.pat - 8'h3b));
		bacc(16'h8010);
		chk("buf_valid", buf_valid_o, 1);
		chk("head", buf_req_o, {1'b1, 20'(3 * 32768 + 16'h1234)});
		bacc(16'h9010);
		stall = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		chk("count", u_mem.got.size(), 2);
		chk("lin", u_mem.got[0], {1'b1, 20'(3 * 32768 + 16'h1234)});
		chk("frm0", u_mem.got[1], fa(5, 12'h010));
		bacc(16'h9010);
		bacc(16'ha010);
		rchk(16'hb123, 8'h00, "unused");
		@(negedge clk_sys_i);
		chk("count", u_mem.got.size(), 4);
		chk("frm1", u_mem.got[2], fa(6, 12'h010));
		chk("frm2", u_mem.got[3], fa(7, 12'h010));
		buf_busy_i = 1'b1;
		wr(OFS_FRAME_LO, 8'h09);
		wr(OFS_FRAME_HI, 8'h00);
		bacc(16'h8000);
		buf_busy_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		wr(OFS_FRAME_LO, 8'h0a);
		bacc(16'h8000);
		@(negedge clk_sys_i);
		chk("busy", u_mem.got[4], fa(5, 12'h000));
		chk("loaded", u_mem.got[5], fa(9, 12'h000));
		$display("done buffer");
	endtask

	task automatic t_rereset;
		@(negedge clk_sys_i);
		rst_n_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		@(negedge clk_sys_i);
		chk("doubler", doubler_on_o, 0);
		chk("pin_oe", pin_oe_o, 0);
		wr(OFS_BAUD_PARITY, 8'h80);
		chk("doubler", doubler_on_o, 1);
		$display("done rereset");
	endtask

	initial begin
		#40000;
		num_errors++;
		give_verdict;
	end

	initial begin
		repeat (4) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		t_reset;
		t_doubler;
		t_baud;
		t_route;
		t_inputs;
		t_regs;
		t_link;
		t_buffer;
		t_rereset;
		give_verdict;
	end
endmodule
